// ===== testbench.sv
/* Self-checking bench for the parallel port block.
   Assumes the pad model and checker are compiled before it. */
`timescale 1ns/1ps
module testbench;
  import tpio_pkg::*;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, busy = 0;
  logic [7:0]  paddr = 0;
  logic [31:0] pwdata = 0, prdata, q;
  logic [3:0]  pstrb = 4'hf;
  logic        pready, pslverr, err, osc, ia0, ia1, ib0;
  logic [6:0]  a_in, a_out, a_oe, a_ext = 0;
  logic [2:0]  b_in, b_out, b_oe, b_ext = 3'h7;
  logic [7:0]  c_in, c_out, c_oe, c_ana, c_ext = 0;
  int          error_cnt = 0, n_checks = 0;
  always #25 pclk = ~pclk;
  tpio_top i_tpio_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .port_a_in(a_in), .port_a_out(a_out), .port_a_oe(a_oe), .port_b_in(b_in), .port_b_out(b_out),
    .port_b_oe(b_oe), .port_c_in(c_in), .port_c_out(c_out), .port_c_oe(c_oe), .port_c_analog_en(c_ana),
    .conv_busy(busy), .low_freq_osc_en(osc), .irq_a0(ia0), .irq_a1(ia1), .irq_b0(ib0));
  tpio_pads i_tpio_pads (.a_out(a_out), .a_oe(a_oe), .a_ext(a_ext), .a_pin(a_in), .b_out(b_out),
    .b_oe(b_oe), .b_ext(b_ext), .b_pin(b_in), .c_out(c_out), .c_oe(c_oe), .c_ext(c_ext), .c_pin(c_in));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
  endtask : idle
  task automatic t_reset();
    a_ext <= 7'h55;
    idle(4);
    apb(0, OFF_A_LATCH, 0); chk(q, 32'h0000_0055);
    apb(0, OFF_IRQ_STAT, 0); chk(q[2:0], 3'h0);
    apb(0, OFF_B_LATCH, 0); chk(q[2:0], 3'h7);
    apb(0, OFF_CONV_CTRL, 0); chk(q, 32'h0000_0100);
    apb(0, OFF_C_DIR, 0); chk(q, 32'h0000_0000);
    apb(1, 8'h40, 32'h0000_ffff); chk(32'(err), 32'h1);
    apb(0, 8'h40, 0); chk({31'h0, err} ^ q, 32'h1);
  endtask : t_reset
  task automatic t_port_a();
    apb(1, OFF_A_LATCH, 32'h0000_000a);
    apb(1, OFF_A_DIR, 32'h0000_000f); chk(a_oe, 7'h0f);
    chk(a_out, 7'h0a);
    idle(4);
    apb(0, OFF_A_LATCH, 0); chk(q, 32'h0000_005a);
    chk(ia1, 1'b1);
    apb(1, OFF_IRQ_STAT, 32'h0000_0002); chk(ia1, 1'b0);
    apb(1, OFF_MODE_CTRL, 32'h0000_0001); chk(a_oe, 7'h0e);
    idle(5);
    chk(ia0, 1'b1);
    apb(1, OFF_MODE_CTRL, 0);
  endtask : t_port_a
  task automatic t_port_b();
    b_ext <= 3'h3;
    apb(1, OFF_B_LATCH, 32'h0000_0006); chk(b_oe, 3'h1);
    idle(4);
    apb(0, OFF_B_PIN, 0); chk(q[2:0], 3'h2);
    apb(0, OFF_B_LATCH, 0); chk(q[2:0], 3'h6);
    chk(ib0, 1'b1);
    apb(1, OFF_MODE_CTRL, 32'h0000_0004); chk(b_oe, 3'h0);
    apb(1, OFF_MODE_CTRL, 32'h0000_0002); chk(osc, 1'b1);
    apb(1, OFF_B_LATCH, 0); chk(b_oe, 3'h1);
    idle(4);
    apb(0, OFF_B_PIN, 0); chk(q[2:0], 3'h0);
    apb(1, OFF_MODE_CTRL, 0); chk(b_oe, 3'h7);
    apb(1, OFF_B_LATCH, 32'h0000_0007);
  endtask : t_port_b
  task automatic t_port_c();
    logic [31:0] v;
    apb(1, OFF_C_LATCH, 32'h0000_00a5);
    apb(1, OFF_C_DIR, 32'h0000_00ff); chk({c_oe, c_out}, 16'hffa5);
    apb(1, OFF_CONV_CTRL, 32'h0000_000f); chk({c_ana, c_oe, c_out}, 24'h0ff0a0);
    apb(1, OFF_C_DIR, 0);
    c_ext <= 8'h3c;
    busy <= 1'b1;
    idle(4);
    apb(0, OFF_C_LATCH, 0); chk(q, 32'h0000_0035);
    v = q;
    apb(0, OFF_CONV_CTRL, 0); chk(q, 32'h0000_020f);
    busy <= 1'b0;
    apb(1, OFF_C_LATCH, v);
    apb(1, OFF_CONV_CTRL, 32'h0000_0100);
    apb(1, OFF_C_DIR, 32'h0000_00ff); chk({c_ana, c_out}, 16'h0035);
  endtask : t_port_c
  task automatic finish_test();
    $display("checks=%0d errors=%0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : finish_test
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_port_a();
    t_port_b();
    t_port_c();
    finish_test();
  end
  initial begin
    repeat (3000) @(posedge pclk);
    error_cnt++;
    finish_test();
  end
endmodule : testbench

// ===== tpio_assertions.sv
/* Checker on the port block's top-level pins.
   Assumes tpio_pkg is compiled first. */
`timescale 1ns/1ps
module tpio_assertions
  import tpio_pkg::*;
(
  input wire logic           pclk,
  input wire logic           presetn,
  input wire logic           psel,
  input wire logic           penable,
  input wire logic           pwrite,
  input wire logic [7:0]     paddr,
  input wire logic [31:0]    pwdata,
  input wire logic [3:0]     pstrb,
  input wire logic [A_W-1:0] port_a_in,
  input wire logic [A_W-1:0] port_a_oe,
  input wire logic [B_W-1:0] port_b_in,
  input wire logic [B_W-1:0] port_b_out,
  input wire logic [B_W-1:0] port_b_oe,
  input wire logic [C_W-1:0] port_c_out,
  input wire logic [C_W-1:0] port_c_oe,
  input wire logic [C_W-1:0] port_c_analog_en,
  input wire logic           low_freq_osc_en,
  input wire logic           irq_a1,
  input wire logic           irq_b0
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic wr = psel && penable && pwrite && pstrb[0];
  property p_rst; $rose(presetn) |-> !(|{port_a_oe, port_b_oe, port_c_oe, low_freq_osc_en}); endproperty
  a_rst: assert property (p_rst) else $error("reset drive");
  property p_adir; wr && paddr == OFF_A_DIR |=> port_a_oe[6:1] == $past(pwdata[6:1]); endproperty
  a_adir: assert property (p_adir) else $error("a dir");
  property p_cdir; wr && paddr == OFF_C_DIR |=> port_c_oe == ($past(pwdata[7:0]) & ~port_c_analog_en); endproperty
  a_cdir: assert property (p_cdir) else $error("c dir");
  property p_cana; ((port_c_oe | port_c_out) & port_c_analog_en) == 8'h00; endproperty
  a_cana: assert property (p_cana) else $error("analog driven");
  property p_bod; port_b_out == 3'h0; endproperty
  a_bod: assert property (p_bod) else $error("b drives high");
  property p_osc; low_freq_osc_en |-> port_b_oe[2:1] == 2'b00; endproperty
  a_osc: assert property (p_osc) else $error("osc pins driven");
  property p_a1; $changed(port_a_in[1]) |-> ##[1:5] irq_a1; endproperty
  a_a1: assert property (p_a1) else $error("a1 edge lost");
  property p_b0; $fell(port_b_in[0]) |-> ##[1:5] irq_b0; endproperty
  a_b0: assert property (p_b0) else $error("b0 edge lost");
endmodule : tpio_assertions
bind tpio_top tpio_assertions i_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .port_a_in(port_a_in),
  .port_a_oe(port_a_oe), .port_b_in(port_b_in), .port_b_out(port_b_out), .port_b_oe(port_b_oe),
  .port_c_out(port_c_out), .port_c_oe(port_c_oe), .port_c_analog_en(port_c_analog_en),
  .low_freq_osc_en(low_freq_osc_en), .irq_a1(irq_a1), .irq_b0(irq_b0));

// ===== tpio_pads.sv
/* Board-side pad model: resolves each pin from the block and the board.
   Assumes port B has a pull-up carried in b_ext. */
`timescale 1ns/1ps
module tpio_pads
  import tpio_pkg::*;
(
  input  wire logic [A_W-1:0] a_out,
  input  wire logic [A_W-1:0] a_oe,
  input  wire logic [A_W-1:0] a_ext,
  output logic      [A_W-1:0] a_pin,
  input  wire logic [B_W-1:0] b_out,
  input  wire logic [B_W-1:0] b_oe,
  input  wire logic [B_W-1:0] b_ext,
  output logic      [B_W-1:0] b_pin,
  input  wire logic [C_W-1:0] c_out,
  input  wire logic [C_W-1:0] c_oe,
  input  wire logic [C_W-1:0] c_ext,
  output logic      [C_W-1:0] c_pin
);
  assign a_pin = (a_out & a_oe) | (a_ext & ~a_oe);
  assign b_pin = (b_out & b_oe) | (b_ext & ~b_oe);
  assign c_pin = (c_out & c_oe) | (c_ext & ~c_oe);
endmodule : tpio_pads

// ===== tpio_pkg.sv
/*
  Package for the three-port parallel I/O block: register offsets,
  port widths, reset values and field positions.
  Assumes a 32-bit APB bus with word-aligned registers.
*/
package tpio_pkg;
  localparam int A_W = 7;
  localparam int B_W = 3;
  localparam int C_W = 8;
  // Byte offsets (all registers one aligned word)
  localparam logic [7:0] OFF_A_LATCH   = 8'h00;
  localparam logic [7:0] OFF_A_DIR     = 8'h04;
  localparam logic [7:0] OFF_B_LATCH   = 8'h08;
  localparam logic [7:0] OFF_B_PIN     = 8'h0C;
  localparam logic [7:0] OFF_C_LATCH   = 8'h10;
  localparam logic [7:0] OFF_C_DIR     = 8'h14;
  localparam logic [7:0] OFF_CONV_CTRL = 8'h18;
  localparam logic [7:0] OFF_MODE_CTRL = 8'h1C;
  localparam logic [7:0] OFF_IRQ_STAT  = 8'h20;
  // Conversion control fields
  localparam int CONV_DIS_BIT = 8;
  localparam int CONV_BUSY_BIT = 9;
  // Mode control fields
  localparam int MODE_IRQSEL_BIT = 0;
  localparam int MODE_DUAL_BIT   = 1;
  localparam int MODE_STOP_BIT   = 2;
  // Interrupt latch status fields (write 1 to clear)
  localparam int IRQ_A0_BIT = 0;
  localparam int IRQ_A1_BIT = 1;
  localparam int IRQ_B0_BIT = 2;
  // Reset values
  localparam logic [A_W-1:0] A_LATCH_RST = 7'h00;
  localparam logic [A_W-1:0] A_DIR_RST   = 7'h00;
  localparam logic [B_W-1:0] B_LATCH_RST = 3'h7;
  localparam logic [C_W-1:0] C_LATCH_RST = 8'h00;
  localparam logic [C_W-1:0] C_DIR_RST   = 8'h00;
  localparam logic           DIS_RST     = 1'b1;
  localparam logic [C_W-1:0] ASEL_RST    = 8'h00;
endpackage : tpio_pkg

// ===== tpio_sync.sv
/*
  Two-flop synchroniser vector for pin inputs.
  Assumes a single clock domain with asynchronous active-low reset.
*/
`timescale 1ns/1ps
module tpio_sync #(
  parameter int W = 8
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule : tpio_sync

// ===== tpio_top.sv
/*
  Three parallel I/O ports behind an APB slave: port latches and
  directions, pin readback, analog masking of port C, resonator
  pins on port B and edge-set interrupt latches.
  Assumes: pins arrive asynchronously; an external pad resolves each
  pin from its output and enable; the converter reports busy.
*/
// Local design decisions: the register addresses and register access over APB.
// Function
// - Port A: seven pins, per-bit direction
// - Port A direction clears on reset
// - Port A latch clears on reset
// - Port A bit one edges set latch
// - Bit zero: I/O or interrupt, reset I/O
// - Port B: three pins, latch resets ones
// - Dual-clock mode gives upper pins to oscillator
// - Port B bit zero falling edge sets latch
// - Port B reads latch or pins separately
// - Port B upper read bits undefined
// - Stop mode floats port B bit zero
// - Port C: eight pins, reset inputs
// - Digital select low makes chosen pins analog
// - Output-mode port C pins drive latch
// - Port C read: latch if analog, else pin
// - Writes never reach analog-selected pins
// - Read-modify-write captures pin levels of inputs
// - Inputs sampled at read, outputs change at write
`timescale 1ns/1ps
module tpio_top
  import tpio_pkg::*;
(
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [7:0]   paddr,
  input  wire logic [31:0]  pwdata,
  input  wire logic [3:0]   pstrb,
  output logic      [31:0]  prdata,
  output logic              pready,
  output logic              pslverr,
  input  wire logic [A_W-1:0] port_a_in,
  output logic      [A_W-1:0] port_a_out,
  output logic      [A_W-1:0] port_a_oe,
  input  wire logic [B_W-1:0] port_b_in,
  output logic      [B_W-1:0] port_b_out,
  output logic      [B_W-1:0] port_b_oe,
  input  wire logic [C_W-1:0] port_c_in,
  output logic      [C_W-1:0] port_c_out,
  output logic      [C_W-1:0] port_c_oe,
  output logic      [C_W-1:0] port_c_analog_en,
  input  wire logic         conv_busy,
  output logic              low_freq_osc_en,
  output logic              irq_a0,
  output logic              irq_a1,
  output logic              irq_b0
);
  // ==========================================================
  // Registers
  logic [A_W-1:0] port_a_latch_r;
  logic [A_W-1:0] port_a_direction_r;
  logic [B_W-1:0] port_b_latch_r;
  logic [C_W-1:0] port_c_latch_r;
  logic [C_W-1:0] port_c_direction_r;
  logic           digital_input_select_r;
  logic [C_W-1:0] analog_channel_select_r;
  logic           irq_pin_function_select_r;
  logic           dual_clock_r;
  logic           stop_mode_r;
  logic [2:0]     irq_lat_r;
  logic [A_W-1:0] a_prev_r;
  logic [B_W-1:0] b_prev_r;
  logic [31:0]    prdata_r;

  logic [A_W-1:0] a_sync;
  logic [B_W-1:0] b_sync;
  logic [C_W-1:0] c_sync;
  logic           busy_sync;

  // ==========================================================
  // Pin synchronisers
  tpio_sync #(.W(A_W)) u_sync_a (
    .pclk    (pclk),
    .presetn (presetn),
    .d       (port_a_in),
    .q       (a_sync)
  );
  tpio_sync #(.W(B_W)) u_sync_b (
    .pclk    (pclk),
    .presetn (presetn),
    .d       (port_b_in),
    .q       (b_sync)
  );
  tpio_sync #(.W(C_W)) u_sync_c (
    .pclk    (pclk),
    .presetn (presetn),
    .d       (port_c_in),
    .q       (c_sync)
  );
  tpio_sync #(.W(1)) u_sync_busy (
    .pclk    (pclk),
    .presetn (presetn),
    .d       (conv_busy),
    .q       (busy_sync)
  );

  // ==========================================================
  // Bus decode
  wire wr_en = psel & penable & pwrite;
  wire rd_en = psel & ~penable & ~pwrite;
  wire wr_lo = wr_en & pstrb[0];
  wire wr_b1 = wr_en & pstrb[1];
  wire sel_a_latch = (paddr == OFF_A_LATCH);
  wire sel_a_dir   = (paddr == OFF_A_DIR);
  wire sel_b_latch = (paddr == OFF_B_LATCH);
  wire sel_b_pin   = (paddr == OFF_B_PIN);
  wire sel_c_latch = (paddr == OFF_C_LATCH);
  wire sel_c_dir   = (paddr == OFF_C_DIR);
  wire sel_conv    = (paddr == OFF_CONV_CTRL);
  wire sel_mode    = (paddr == OFF_MODE_CTRL);
  wire sel_irq     = (paddr == OFF_IRQ_STAT);
  wire mapped = sel_a_latch | sel_a_dir | sel_b_latch | sel_b_pin | sel_c_latch |
                sel_c_dir | sel_conv | sel_mode | sel_irq;

  // ==========================================================
  // Register write enables
  wire we_a_latch = wr_lo & sel_a_latch;
  wire we_a_dir   = wr_lo & sel_a_dir;
  wire we_b_latch = wr_lo & sel_b_latch;
  wire we_c_latch = wr_lo & sel_c_latch;
  wire we_c_dir   = wr_lo & sel_c_dir;
  wire we_asel    = wr_lo & sel_conv;
  wire we_dis     = wr_b1 & sel_conv;
  wire we_mode    = wr_lo & sel_mode;
  wire we_irq     = wr_lo & sel_irq;

  // ==========================================================
  // Pin behaviour
  // Analog-selected pins of port C
  wire [C_W-1:0] analog_sel = digital_input_select_r ? '0 : analog_channel_select_r;
  // Port B pins given to the resonator
  wire [B_W-1:0] osc_pins = dual_clock_r ? 3'b110 : 3'b000;

  // Port A readback: pin for inputs, latch for outputs
  wire [A_W-1:0] a_read = (port_a_direction_r & port_a_latch_r) |
                          (~port_a_direction_r & a_sync);
  // Port C readback: latch for analog pins, pin otherwise
  wire [C_W-1:0] c_read = (analog_sel & port_c_latch_r) | (~analog_sel & c_sync);
  wire [B_W-1:0] b_read_pin = b_sync & ~osc_pins;

  // ==========================================================
  // Read mux (sampled during setup phase)
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (sel_a_latch) rd_mux[A_W-1:0] = a_read;
    if (sel_a_dir)   rd_mux[A_W-1:0] = port_a_direction_r;
    if (sel_b_latch) rd_mux[B_W-1:0] = port_b_latch_r;
    if (sel_b_pin)   rd_mux[B_W-1:0] = b_read_pin;
    if (sel_c_latch) rd_mux[C_W-1:0] = c_read;
    if (sel_c_dir)   rd_mux[C_W-1:0] = port_c_direction_r;
    if (sel_conv) begin
      rd_mux[C_W-1:0]     = analog_channel_select_r;
      rd_mux[CONV_DIS_BIT]  = digital_input_select_r;
      rd_mux[CONV_BUSY_BIT] = busy_sync;
    end
    if (sel_mode) begin
      rd_mux[MODE_IRQSEL_BIT] = irq_pin_function_select_r;
      rd_mux[MODE_DUAL_BIT]   = dual_clock_r;
      rd_mux[MODE_STOP_BIT]   = stop_mode_r;
    end
    if (sel_irq) rd_mux[2:0] = irq_lat_r;
  end

  // Input data captured in the first state of the read cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
    end else if (rd_en) begin
      prdata_r <= rd_mux;
    end
  end

  assign prdata  = prdata_r;
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  // ==========================================================
  // Port latches and direction
  // Written value lands whole; a read-modify-write carries pin levels back
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_a_latch_r <= A_LATCH_RST;
    end else if (we_a_latch) begin
      port_a_latch_r <= pwdata[A_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_a_direction_r <= A_DIR_RST;
    end else if (we_a_dir) begin
      port_a_direction_r <= pwdata[A_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_b_latch_r <= B_LATCH_RST;
    end else if (we_b_latch) begin
      port_b_latch_r <= pwdata[B_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_c_latch_r <= C_LATCH_RST;
    end else if (we_c_latch) begin
      port_c_latch_r <= pwdata[C_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_c_direction_r <= C_DIR_RST;
    end else if (we_c_dir) begin
      port_c_direction_r <= pwdata[C_W-1:0];
    end
  end

  // ==========================================================
  // Control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      analog_channel_select_r <= ASEL_RST;
    end else if (we_asel) begin
      analog_channel_select_r <= pwdata[C_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      digital_input_select_r <= DIS_RST;
    end else if (we_dis) begin
      digital_input_select_r <= pwdata[CONV_DIS_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_pin_function_select_r <= 1'b0;
    end else if (we_mode) begin
      irq_pin_function_select_r <= pwdata[MODE_IRQSEL_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dual_clock_r <= 1'b0;
    end else if (we_mode) begin
      dual_clock_r <= pwdata[MODE_DUAL_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stop_mode_r <= 1'b0;
    end else if (we_mode) begin
      stop_mode_r <= pwdata[MODE_STOP_BIT];
    end
  end

  // ==========================================================
  // Pin drivers
  wire [A_W-1:0] a_oe_raw = port_a_direction_r;
  // Bit zero in interrupt role is input only
  assign port_a_oe  = {a_oe_raw[A_W-1:1], a_oe_raw[0] & ~irq_pin_function_select_r};
  assign port_a_out = port_a_latch_r;

  // Open drain: low on zero, released on one
  wire [B_W-1:0] b_pull = ~port_b_latch_r & ~osc_pins;
  assign port_b_oe  = {b_pull[B_W-1:1], b_pull[0] & ~stop_mode_r};
  assign port_b_out = '0;
  assign low_freq_osc_en = dual_clock_r;

  // Per-pin drive of port C, masked off on analog pins
  for (genvar gi = 0; gi < C_W; gi++) begin : g_port_c
    assign port_c_oe[gi]        = port_c_direction_r[gi] & ~analog_sel[gi];
    assign port_c_out[gi]       = port_c_latch_r[gi] & ~analog_sel[gi];
    assign port_c_analog_en[gi] = analog_sel[gi];
  end

  // ==========================================================
  // Interrupt latches (set wins over clear)
  // Edge detection held off until synchronisers carry real pin levels
  logic [1:0] arm_cnt_r;
  wire        edges_armed = &arm_cnt_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      arm_cnt_r <= 2'b00;
    end else if (!edges_armed) begin
      arm_cnt_r <= arm_cnt_r + 2'b01;
    end
  end

  wire a0_edge = edges_armed & irq_pin_function_select_r & (a_sync[0] ^ a_prev_r[0]);
  wire a1_edge = edges_armed & (a_sync[1] ^ a_prev_r[1]);
  wire b0_edge = edges_armed & b_prev_r[0] & ~b_sync[0];
  wire [2:0] irq_set = {b0_edge, a1_edge, a0_edge};
  wire [2:0] irq_clr = we_irq ? pwdata[2:0] : 3'b000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      a_prev_r <= '0;
      b_prev_r <= B_LATCH_RST;
    end else begin
      a_prev_r <= a_sync;
      b_prev_r <= b_sync;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_lat_r <= 3'b000;
    end else begin
      irq_lat_r <= irq_set | (irq_lat_r & ~irq_clr);
    end
  end

  assign irq_a0 = irq_lat_r[IRQ_A0_BIT];
  assign irq_a1 = irq_lat_r[IRQ_A1_BIT];
  assign irq_b0 = irq_lat_r[IRQ_B0_BIT];
endmodule : tpio_top
